// >>> core/csm_pkg.sv
/*
  Shared constants for the processor state and privilege-mode controller:
  state codes, power-down modes, register offsets, field positions and
  reset values.
  Assumes a 32-bit register port with byte offsets, one word apart.
*/
package csm_pkg;

  // ----------------------------------------------------------------
  // Processor states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CSM_ST_RESET   = 3'h0,
    CSM_ST_EXCEPT  = 3'h1,
    CSM_ST_BUSREL  = 3'h2,
    CSM_ST_EXEC    = 3'h3,
    CSM_ST_PDOWN   = 3'h4
  } csm_state_t;

  // ----------------------------------------------------------------
  // Power-down modes and reset kinds
  // ----------------------------------------------------------------
  localparam logic [1:0] PD_SLEEP = 2'h0;
  localparam logic [1:0] PD_SW_STANDBY = 2'h1;
  localparam logic [1:0] PD_HW_STANDBY = 2'h2;
  localparam logic [1:0] RK_NONE = 2'h0;
  localparam logic [1:0] RK_POWER_ON = 2'h1;
  localparam logic [1:0] RK_MANUAL = 2'h2;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_VECTOR_BASE = 8'h04;
  localparam logic [7:0] REG_STATUS_WORD = 8'h08;
  localparam logic [7:0] REG_SAVED_PC = 8'h0C;
  localparam logic [7:0] REG_SAVED_SW = 8'h10;
  localparam logic [7:0] REG_STATE = 8'h14;
  localparam logic [7:0] REG_INT_STATUS = 8'h18;
  localparam logic [7:0] REG_INT_MASK = 8'h1C;
  localparam logic [7:0] REG_BUS_SEQ_CFG = 8'h20;
  localparam logic [7:0] REG_PC = 8'h24;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int PRIV_BIT = 30;
  localparam int NUM_EVENTS = 5;
  localparam int EV_EXCEPT = 0;
  localparam int EV_RESET_DONE = 1;
  localparam int EV_BUS_RELEASE = 2;
  localparam int EV_WAKE = 3;
  localparam int EV_PRIV_FAULT = 4;
  localparam logic [31:0] RESET_VECTOR = 32'hA0000000;
  localparam logic [31:0] STATUS_WORD_RST = 32'h40000000;
  localparam logic [31:0] PC_STEP = 32'h00000002;
  localparam logic [3:0] PIN_SYNC_RST = 4'hA;

endpackage

// >>> core/csm_sync.sv
/*
  Three-stage input synchroniser with agreement filter.
  Assumes inputs are asynchronous to clk_i; an output changes only when
  stages two and three agree.
*/
`timescale 1ns/1ps
`default_nettype none

module csm_sync #(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk_i,               // Core clock
  input wire logic resetn_i,            // Async reset, active low
  input wire logic [WIDTH-1:0] async_i, // Raw pin levels
  output logic [WIDTH-1:0] sync_o       // Filtered levels
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (WIDTH < 1) begin : g_chk
    $error("csm_sync: WIDTH must be at least 1");
  end

  // ----------------------------------------------------------------
  // Stages
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_sync;

  // Stage one feeds only stage two, so metastability stays contained
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stage1 <= RST_VAL;
      stage2 <= RST_VAL;
      stage3 <= RST_VAL;
      sync_o <= RST_VAL;
    end else begin
      stage1 <= async_i;
      stage2 <= stage1;
      stage3 <= stage2;
      sync_o <= next_sync;
    end
  end

  // Bits take the new level only where the last two stages agree
  assign next_sync = (stage3 & ~(stage2 ^ stage3)) | (sync_o & (stage2 ^ stage3));

endmodule

`default_nettype wire

// >>> core/csm_core.sv
/*
  Processor state and privilege-mode controller: five-state sequencer,
  reset entry, exception save and vectoring, privilege bit, register port
  and interrupt.
  Assumes the pipeline supplies step, exception, return and sleep strobes
  on clk_i; reset, bus request and standby pins are asynchronous.
*/
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module csm_core #(
  parameter int OFFSET_W = 12
) (
  input wire logic clk_i,               // Core clock, 10 MHz
  input wire logic resetn_i,            // Async reset, active low
  input wire logic power_on_reset_n_i,  // Power-on reset pin
  input wire logic manual_reset_n_i,    // Manual reset pin
  input wire logic hw_standby_n_i,      // Hardware standby pin
  input wire logic bus_req_i,           // External bus request pin
  input wire logic step_i,              // Instruction completed
  input wire logic exc_req_i,           // General exception or interrupt
  input wire logic [OFFSET_W-1:0] exc_offset_i, // Vector offset of cause
  input wire logic exc_return_i,        // Exception handling finished
  input wire logic sleep_i,             // Sleep instruction executed
  input wire logic wake_i,              // Wake-up interrupt request
  input wire logic [7:0] addr_i,        // Register byte address
  input wire logic [31:0] wdata_i,      // Register write data
  input wire logic we_i,                // Write strobe
  input wire logic re_i,                // Read strobe
  output logic [31:0] rdata_o,          // Read data, cycle after strobe
  output logic [31:0] pc_o,             // Fetch address
  output logic fetch_en_o,              // Fetch allowed
  output logic [2:0] state_o,           // Processor state code
  output logic [1:0] pd_mode_o,         // Power-down mode
  output logic privilege_o,             // Privilege bit
  output logic bus_grant_o,             // Bus released to requester
  output logic periph_reset_o,          // Module registers in reset
  output logic bus_seq_reset_o,         // Bus sequencer registers in reset
  output logic irq_o                    // Interrupt, active high level
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (OFFSET_W < 1 || OFFSET_W > 32) begin : g_chk
    $error("csm_core: OFFSET_W must be 1 to 32");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [3:0] pins;
  logic por_n;
  logic man_n;
  logic bus_req;
  logic hws_n;
  csm_pkg::csm_state_t state;
  csm_pkg::csm_state_t next_state;
  logic [1:0] reset_kind;
  logic [1:0] next_reset_kind;
  logic [1:0] pd_mode;
  logic [1:0] next_pd_mode;
  logic [31:0] pc;
  logic [31:0] next_pc;
  logic [31:0] status_word;
  logic [31:0] next_status_word;
  logic [31:0] saved_program_counter;
  logic [31:0] next_saved_pc;
  logic [31:0] saved_status_word;
  logic [31:0] next_saved_sw;
  logic [31:0] vector_base;
  logic [1:0] ctrl_standby;
  logic [31:0] bus_seq_cfg;
  logic [csm_pkg::NUM_EVENTS-1:0] int_status;
  logic [csm_pkg::NUM_EVENTS-1:0] int_mask;
  logic [csm_pkg::NUM_EVENTS-1:0] events;
  logic [csm_pkg::NUM_EVENTS-1:0] w1c;
  logic [31:0] next_rdata;
  logic [31:0] vector_addr;
  logic privilege_bit;
  logic in_reset;
  logic por_active;
  logic wr_ok;
  logic wr_fault;
  logic rd_ok;
  logic enter_exc;
  logic leave_reset;
  logic do_return;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Registers that user-mode software may not touch
  function automatic logic is_priv_reg(input logic [7:0] a);
    is_priv_reg = (a == csm_pkg::REG_CTRL) || (a == csm_pkg::REG_VECTOR_BASE) ||
                  (a == csm_pkg::REG_STATUS_WORD) || (a == csm_pkg::REG_SAVED_PC) ||
                  (a == csm_pkg::REG_SAVED_SW) || (a == csm_pkg::REG_INT_MASK) ||
                  (a == csm_pkg::REG_BUS_SEQ_CFG);
  endfunction

  // Status word with the privilege bit replaced
  function automatic logic [31:0] with_priv(input logic [31:0] sw, input logic p);
    logic [31:0] r;
    r = sw;
    r[csm_pkg::PRIV_BIT] = p;
    with_priv = r;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  csm_sync #(
    .WIDTH(4),
    .RST_VAL(csm_pkg::PIN_SYNC_RST)
  ) u_sync (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .async_i({hw_standby_n_i, manual_reset_n_i, bus_req_i, power_on_reset_n_i}),
    .sync_o(pins)
  );

  assign por_n = pins[0];
  assign bus_req = pins[1];
  assign man_n = pins[2];
  assign hws_n = pins[3];

  // ----------------------------------------------------------------
  // Mode and reset decode
  // ----------------------------------------------------------------
  // Privilege bit selects user (0) or privileged (1) mode
  assign privilege_bit = status_word[csm_pkg::PRIV_BIT];
  assign in_reset = !por_n || !man_n;
  assign por_active = !por_n;
  assign leave_reset = (state == csm_pkg::CSM_ST_RESET) && !in_reset;
  assign do_return = (state == csm_pkg::CSM_ST_EXEC) && exc_return_i && !exc_req_i;
  assign vector_addr = vector_base + 32'(exc_offset_i);

  // ----------------------------------------------------------------
  // State sequencer
  // ----------------------------------------------------------------
  // Reset pins override everything; codes five to seven fall back to reset
  always_comb begin
    next_state = state;
    next_pd_mode = pd_mode;
    next_reset_kind = reset_kind;
    if (in_reset) begin
      next_state = csm_pkg::CSM_ST_RESET;
      next_reset_kind = por_active ? csm_pkg::RK_POWER_ON : csm_pkg::RK_MANUAL;
    end else begin
      unique case (state)
        csm_pkg::CSM_ST_RESET: begin
          next_state = csm_pkg::CSM_ST_EXCEPT;
        end
        csm_pkg::CSM_ST_EXCEPT: begin
          next_state = csm_pkg::CSM_ST_EXEC;
        end
        csm_pkg::CSM_ST_BUSREL: begin
          if (!hws_n) begin
            next_state = csm_pkg::CSM_ST_PDOWN;
            next_pd_mode = csm_pkg::PD_HW_STANDBY;
          end else if (!bus_req) begin
            next_state = csm_pkg::CSM_ST_EXEC;
          end
        end
        csm_pkg::CSM_ST_EXEC: begin
          if (!hws_n) begin
            next_state = csm_pkg::CSM_ST_PDOWN;
            next_pd_mode = csm_pkg::PD_HW_STANDBY;
          end else if (bus_req) begin
            next_state = csm_pkg::CSM_ST_BUSREL;
          end else if (exc_req_i) begin
            next_state = csm_pkg::CSM_ST_EXCEPT;
          end else if (sleep_i) begin
            next_state = csm_pkg::CSM_ST_PDOWN;
            next_pd_mode = ctrl_standby;
          end
        end
        csm_pkg::CSM_ST_PDOWN: begin
          if (pd_mode == csm_pkg::PD_HW_STANDBY) begin
            if (hws_n) begin
              next_state = csm_pkg::CSM_ST_EXEC;
            end
          end else if (!hws_n) begin
            next_pd_mode = csm_pkg::PD_HW_STANDBY;
          end else if (wake_i) begin
            next_state = csm_pkg::CSM_ST_EXCEPT;
          end
        end
        default: begin
          next_state = csm_pkg::CSM_ST_RESET;
        end
      endcase
    end
  end

  // Exception entry from execution or a wake-up out of power-down
  assign enter_exc = (next_state == csm_pkg::CSM_ST_EXCEPT) &&
                     ((state == csm_pkg::CSM_ST_EXEC) || (state == csm_pkg::CSM_ST_PDOWN));

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= csm_pkg::CSM_ST_RESET;
      pd_mode <= csm_pkg::PD_SLEEP;
      reset_kind <= csm_pkg::RK_POWER_ON;
    end else begin
      state <= next_state;
      pd_mode <= next_pd_mode;
      reset_kind <= next_reset_kind;
    end
  end

  // ----------------------------------------------------------------
  // Program counter, status word and saved copies
  // ----------------------------------------------------------------
  // Hardware updates outrank a software write in the same cycle
  always_comb begin
    next_pc = pc;
    next_status_word = status_word;
    next_saved_pc = saved_program_counter;
    next_saved_sw = saved_status_word;
    if (in_reset) begin
      next_status_word = with_priv(csm_pkg::STATUS_WORD_RST, 1'b1);
      next_saved_pc = '0;
      next_saved_sw = '0;
      next_pc = csm_pkg::RESET_VECTOR;
    end else if (leave_reset) begin
      next_pc = csm_pkg::RESET_VECTOR;
      next_status_word = with_priv(status_word, 1'b1);
    end else if (enter_exc) begin
      next_saved_pc = pc;
      next_saved_sw = status_word;
      next_pc = vector_addr;
      next_status_word = with_priv(status_word, 1'b1);
    end else if (do_return) begin
      next_pc = saved_program_counter;
      next_status_word = with_priv(saved_status_word, 1'b0);
    end else begin
      if ((state == csm_pkg::CSM_ST_EXEC) && step_i && !exc_req_i && !bus_req && hws_n) begin
        next_pc = pc + csm_pkg::PC_STEP;
      end
      if (wr_ok && (addr_i == csm_pkg::REG_STATUS_WORD)) begin
        next_status_word = wdata_i;
      end
      if (wr_ok && (addr_i == csm_pkg::REG_SAVED_PC)) begin
        next_saved_pc = wdata_i;
      end
      if (wr_ok && (addr_i == csm_pkg::REG_SAVED_SW)) begin
        next_saved_sw = wdata_i;
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pc <= csm_pkg::RESET_VECTOR;
      status_word <= csm_pkg::STATUS_WORD_RST;
      saved_program_counter <= '0;
      saved_status_word <= '0;
    end else begin
      pc <= next_pc;
      status_word <= next_status_word;
      saved_program_counter <= next_saved_pc;
      saved_status_word <= next_saved_sw;
    end
  end

  // ----------------------------------------------------------------
  // Register port decode
  // ----------------------------------------------------------------
  // User-mode writes to protected registers are dropped and flagged
  assign wr_ok = we_i && !in_reset && (!is_priv_reg(addr_i) || privilege_bit);
  assign wr_fault = (we_i || re_i) && is_priv_reg(addr_i) && !privilege_bit;
  assign rd_ok = !is_priv_reg(addr_i) || privilege_bit;

  // Control and configuration registers
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      vector_base <= '0;
      ctrl_standby <= csm_pkg::PD_SLEEP;
      int_mask <= '0;
    end else if (in_reset) begin
      vector_base <= '0;
      ctrl_standby <= csm_pkg::PD_SLEEP;
      int_mask <= '0;
    end else if (wr_ok) begin
      if (addr_i == csm_pkg::REG_VECTOR_BASE) vector_base <= wdata_i;
      if (addr_i == csm_pkg::REG_CTRL) ctrl_standby <= {1'b0, wdata_i[0]};
      if (addr_i == csm_pkg::REG_INT_MASK) int_mask <= wdata_i[csm_pkg::NUM_EVENTS-1:0];
    end
  end

  // Bus sequencer settings survive a manual reset
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bus_seq_cfg <= '0;
    end else if (por_active) begin
      bus_seq_cfg <= '0;
    end else if (wr_ok && (addr_i == csm_pkg::REG_BUS_SEQ_CFG)) begin
      bus_seq_cfg <= wdata_i;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------
  // Set beats a write-one clear landing in the same cycle
  assign events[csm_pkg::EV_EXCEPT] = enter_exc;
  assign events[csm_pkg::EV_RESET_DONE] = leave_reset;
  assign events[csm_pkg::EV_BUS_RELEASE] = (next_state == csm_pkg::CSM_ST_BUSREL) &&
                                           (state != csm_pkg::CSM_ST_BUSREL);
  assign events[csm_pkg::EV_WAKE] = (state == csm_pkg::CSM_ST_PDOWN) &&
                                    (next_state != csm_pkg::CSM_ST_PDOWN);
  assign events[csm_pkg::EV_PRIV_FAULT] = wr_fault;
  assign w1c = (we_i && (addr_i == csm_pkg::REG_INT_STATUS)) ?
               wdata_i[csm_pkg::NUM_EVENTS-1:0] : '0;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      int_status <= '0;
    end else begin
      int_status <= (int_status & ~w1c) | events;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Protected offsets read as zero in user mode; unmapped offsets always do
  always_comb begin
    next_rdata = '0;
    if (re_i && rd_ok) begin
      unique case (addr_i)
        csm_pkg::REG_CTRL: next_rdata = {30'h0, ctrl_standby};
        csm_pkg::REG_VECTOR_BASE: next_rdata = vector_base;
        csm_pkg::REG_STATUS_WORD: next_rdata = status_word;
        csm_pkg::REG_SAVED_PC: next_rdata = saved_program_counter;
        csm_pkg::REG_SAVED_SW: next_rdata = saved_status_word;
        csm_pkg::REG_STATE: next_rdata = {23'h0, privilege_bit, 1'b0, pd_mode, reset_kind, state};
        csm_pkg::REG_INT_STATUS: next_rdata = {27'h0, int_status};
        csm_pkg::REG_INT_MASK: next_rdata = {27'h0, int_mask};
        csm_pkg::REG_BUS_SEQ_CFG: next_rdata = bus_seq_cfg;
        csm_pkg::REG_PC: next_rdata = pc;
        default: next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Fetch stops outside execution so power-down really halts the core
  assign pc_o = pc;
  assign state_o = state;
  assign pd_mode_o = pd_mode;
  assign privilege_o = privilege_bit;
  assign fetch_en_o = (state == csm_pkg::CSM_ST_EXEC);
  assign bus_grant_o = (state == csm_pkg::CSM_ST_BUSREL);
  assign periph_reset_o = (state == csm_pkg::CSM_ST_RESET);
  assign bus_seq_reset_o = (state == csm_pkg::CSM_ST_RESET) &&
                           (reset_kind == csm_pkg::RK_POWER_ON);
  assign irq_o = |(int_status & int_mask);

endmodule

`default_nettype wire

// >>> sim/csm_props.sv
/*
  Port checker for the state and privilege-mode controller.
  Assumes it is bound to csm_core and sees only that module's ports.
*/
`timescale 1ns/1ps
`default_nettype none

module csm_props (
  input wire logic clk_i,           // Core clock
  input wire logic resetn_i,        // Async reset, active low
  input wire logic step_i,          // Instruction done
  input wire logic exc_req_i,       // Exception request
  input wire logic exc_return_i,    // Handler finished
  input wire logic sleep_i,         // Sleep strobe
  input wire logic wake_i,          // Wake request
  input wire logic [31:0] pc_o,     // Fetch address
  input wire logic fetch_en_o,      // Fetch allowed
  input wire logic [2:0] state_o,   // State code
  input wire logic privilege_o,     // Privilege bit
  input wire logic bus_grant_o,     // Bus released
  input wire logic periph_reset_o,  // Modules in reset
  input wire logic bus_seq_reset_o  // Sequencer in reset
);
  // --------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------
  // One domain, so clock and reset are given once
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  state_range_a: assert property (state_o <= 3'h4)
    else $error("state code out of range");
  reset_out_a: assert property (periph_reset_o == (state_o == 3'h0))
    else $error("module reset does not follow reset state");
  seq_kept_a: assert property (bus_seq_reset_o |-> periph_reset_o)
    else $error("sequencer reset outside reset state");
  reset_vec_a: assert property (state_o == 3'h1 && $past(state_o) == 3'h0 |->
    pc_o == csm_pkg::RESET_VECTOR) else $error("wrong address after reset");
  exc_short_a: assert property (state_o == 3'h1 |=> state_o == 3'h3)
    else $error("exception state not left in one cycle");
  exc_priv_a: assert property (state_o == 3'h1 |-> privilege_o)
    else $error("privilege not forced in exception state");
  pc_step_a: assert property ((state_o == 3'h3 && step_i && !exc_req_i && !sleep_i &&
    !exc_return_i) ##1 state_o == 3'h3 |-> pc_o == $past(pc_o) + csm_pkg::PC_STEP)
    else $error("program counter did not advance by one step");
  fetch_gate_a: assert property (fetch_en_o == (state_o == 3'h3))
    else $error("fetch enable outside execution");
  pd_halt_a: assert property (state_o == 3'h4 && !wake_i |=> $stable(pc_o))
    else $error("program counter moved in power-down");
  grant_a: assert property (bus_grant_o == (state_o == 3'h2))
    else $error("grant does not match bus-released state");
  return_user_a: assert property (state_o == 3'h3 && exc_return_i && !exc_req_i |=>
    !privilege_o) else $error("privilege kept after handler return");

  // Main scenarios reached
  cover property (state_o == 3'h2);
  cover property (state_o == 3'h4);
  cover property (bus_seq_reset_o);
  cover property (state_o == 3'h1 ##1 state_o == 3'h3);
endmodule

bind csm_core csm_props u_props (.*);
`default_nettype wire

// >>> sim/csm_pins.sv
/*
  Far-side model: reset sources, standby pin and one bus requester.
  Assumes the bench commands it on clk_i; pins move one edge after a command.
*/
`timescale 1ns/1ps
`default_nettype none

module csm_pins #(
  parameter int HOLD = 4
) (
  input wire logic clk_i,          // Core clock
  input wire logic [2:0] pin_cmd_i, // Assert: power-on, manual, standby
  input wire logic bus_start_i,    // Begin one bus tenure
  input wire logic bus_grant_i,    // Core has let go of the bus
  output logic power_on_reset_n_o, // Power-on reset pin
  output logic manual_reset_n_o,   // Manual reset pin
  output logic hw_standby_n_o,     // Standby pin
  output logic bus_req_o           // Bus request pin
);
  // --------------------------------------------------------------
  // Pin drivers
  // --------------------------------------------------------------
  int held = 0;
  initial begin
    power_on_reset_n_o = 1'b1;
    manual_reset_n_o = 1'b1;
    hw_standby_n_o = 1'b1;
    bus_req_o = 1'b0;
  end
  // Request is held for HOLD granted cycles, so a slow core still sees it
  always @(posedge clk_i) begin
    power_on_reset_n_o <= !pin_cmd_i[0];
    manual_reset_n_o <= !pin_cmd_i[1];
    hw_standby_n_o <= !pin_cmd_i[2];
    if (bus_start_i) begin
      bus_req_o <= 1'b1;
      held <= 0;
    end else if (bus_req_o && bus_grant_i) begin
      held <= held + 1;
      bus_req_o <= (held < HOLD - 1);
    end
  end
endmodule
`default_nettype wire

// >>> sim/tb_cpu_state_mode_control.sv
/*
  Bench for the state and privilege-mode controller.
  Assumes csm_pkg, csm_core, csm_pins and csm_props are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("unexpected at %0t: got %h want %h", $time, a, e); end end

module tb_cpu_state_mode_control;
  logic clk_i = 1'b0, resetn_i = 1'b0, step_i = 1'b0, exc_req_i = 1'b0, exc_return_i = 1'b0;
  logic sleep_i = 1'b0, wake_i = 1'b0, we_i = 1'b0, re_i = 1'b0, bus_start = 1'b0;
  logic [11:0] exc_offset_i = 12'h000;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h00000000;
  logic [2:0] pin_cmd = 3'h0;
  logic [31:0] rdata_o, pc_o;
  logic [2:0] state_o;
  logic [1:0] pd_mode_o;
  logic fetch_en_o, privilege_o, bus_grant_o, periph_reset_o, bus_seq_reset_o, irq_o;
  logic power_on_reset_n_i, manual_reset_n_i, hw_standby_n_i, bus_req_i;
  int error_cnt = 0, total_checks = 0;

  // --------------------------------------------------------------
  // Clock, design and far side
  // --------------------------------------------------------------
  always #50 clk_i = ~clk_i;
  csm_core u_dut (.*);
  csm_pins #(.HOLD(6)) u_pins (.clk_i(clk_i), .pin_cmd_i(pin_cmd), .bus_start_i(bus_start),
    .bus_grant_i(bus_grant_o), .power_on_reset_n_o(power_on_reset_n_i),
    .manual_reset_n_o(manual_reset_n_i), .hw_standby_n_o(hw_standby_n_i),
    .bus_req_o(bus_req_i));

  // Register accesses keep a gap so a strobe is never set twice in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr_i <= a;
    wdata_i <= d;
    we_i <= 1'b1;
    @(posedge clk_i);
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    addr_i <= a;
    re_i <= 1'b1;
    @(posedge clk_i);
    re_i <= 1'b0;
    #1 `CHK(rdata_o, e)
    @(posedge clk_i);
  endtask
  task automatic wait_st(input logic [2:0] s);
    for (int n = 0; n < 60 && state_o !== s; n++) @(posedge clk_i) #1;
    `CHK(state_o, s)
  endtask
  task automatic conclude();
    $display("errors %0d checks %0d", error_cnt, total_checks);
    if (error_cnt == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // --------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk_i);
    resetn_i <= 1'b1;
    wait_st(3'h1);
    `CHK(pc_o, csm_pkg::RESET_VECTOR)
    `CHK(privilege_o, 1'b1)
    wait_st(3'h3);
    `CHK(fetch_en_o, 1'b1)
    wr(csm_pkg::REG_BUS_SEQ_CFG, 32'h0000005A);
    wr(csm_pkg::REG_VECTOR_BASE, 32'h00000100);
    wr(csm_pkg::REG_INT_MASK, 32'h0000001F);
    wr(csm_pkg::REG_INT_STATUS, 32'h0000001F);
    `CHK(irq_o, 1'b0)
    rd(csm_pkg::REG_VECTOR_BASE, 32'h00000100);
    step_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    step_i <= 1'b0;
    #1 `CHK(pc_o, 32'hA0000006)
    exc_offset_i <= 12'h040;
    exc_req_i <= 1'b1;
    @(posedge clk_i);
    exc_req_i <= 1'b0;
    #1 `CHK(pc_o, 32'h00000140)
    `CHK(irq_o, 1'b1)
    rd(csm_pkg::REG_SAVED_PC, 32'hA0000006);
    rd(csm_pkg::REG_SAVED_SW, csm_pkg::STATUS_WORD_RST);
    // Sleep then software standby, each left by a wake request
    for (int m = 0; m < 2; m++) begin
      wr(csm_pkg::REG_CTRL, 32'(m));
      sleep_i <= 1'b1;
      @(posedge clk_i);
      sleep_i <= 1'b0;
      step_i <= 1'b1;
      #1 `CHK(pd_mode_o, 2'(m))
      @(posedge clk_i);
      step_i <= 1'b0;
      exc_offset_i <= 12'h080;
      wake_i <= 1'b1;
      @(posedge clk_i);
      wake_i <= 1'b0;
      #1 `CHK(pc_o, 32'h00000180)
      wait_st(3'h3);
    end
    pin_cmd <= 3'b100;
    wait_st(3'h4);
    `CHK(pd_mode_o, csm_pkg::PD_HW_STANDBY)
    pin_cmd <= 3'b000;
    wait_st(3'h3);
    // Bus release event is masked, so the line stays low
    wr(csm_pkg::REG_INT_MASK, 32'h0000001B);
    wr(csm_pkg::REG_INT_STATUS, 32'h0000001F);
    bus_start <= 1'b1;
    @(posedge clk_i);
    bus_start <= 1'b0;
    wait_st(3'h2);
    `CHK(bus_grant_o, 1'b1)
    wait_st(3'h3);
    `CHK(irq_o, 1'b0)
    rd(csm_pkg::REG_INT_STATUS, 32'h00000004);
    wr(csm_pkg::REG_INT_STATUS, 32'h0000001F);
    exc_return_i <= 1'b1;
    @(posedge clk_i);
    exc_return_i <= 1'b0;
    #1 `CHK(privilege_o, 1'b0)
    `CHK(pc_o, 32'h00000180)
    wr(csm_pkg::REG_VECTOR_BASE, 32'h00000200);
    rd(csm_pkg::REG_VECTOR_BASE, 32'h00000000);
    rd(csm_pkg::REG_INT_STATUS, 32'h00000010);
    pin_cmd <= 3'b010;
    wait_st(3'h0);
    repeat (8) @(posedge clk_i);
    #1 `CHK(state_o, 3'h0)
    `CHK(bus_seq_reset_o, 1'b0)
    `CHK(periph_reset_o, 1'b1)
    pin_cmd <= 3'b000;
    wait_st(3'h1);
    `CHK(privilege_o, 1'b1)
    wait_st(3'h3);
    rd(csm_pkg::REG_BUS_SEQ_CFG, 32'h0000005A);
    rd(csm_pkg::REG_VECTOR_BASE, 32'h00000000);
    pin_cmd <= 3'b011;
    wait_st(3'h0);
    `CHK(bus_seq_reset_o, 1'b1)
    pin_cmd <= 3'b000;
    wait_st(3'h3);
    rd(csm_pkg::REG_BUS_SEQ_CFG, 32'h00000000);
    conclude();
  end

  // Whole run is well under two hundred cycles; the limit is 4000
  initial begin
    #(4000 * 100);
    error_cnt++;
    conclude();
  end
endmodule
`default_nettype wire
